// [design/ifeb_map.svh]
/*
 * Offsets, bit layouts, reset values and bus codes of the flag and enable bank.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`ifndef IFEB_MAP_SVH
`define IFEB_MAP_SVH

// Byte offsets, one aligned word each
`define IFEB_OFF_FLAGS1   8'h00
`define IFEB_OFF_FLAGS3   8'h04
`define IFEB_OFF_FLAGS4   8'h08
`define IFEB_OFF_EN0      8'h0C

// Implemented bit masks
`define IFEB_MASK_FLAGS1  16'hE01F
`define IFEB_MASK_FLAGS3  16'h4000
`define IFEB_MASK_FLAGS4  16'h210E
`define IFEB_MASK_EN0     16'hBF8F

// Power-on value of every register
`define IFEB_RST_VAL      16'h0000

// Bit positions of named fields
`define IFEB_B_UART_B_TX_FLAG    15
`define IFEB_B_CALENDAR_CLOCK    14
`define IFEB_B_CHARGE_TIME_UNIT  13
`define IFEB_B_VOLTAGE_DETECT    8
`define IFEB_B_CHECKSUM_GEN      3
`define IFEB_B_NONVOLATILE_EN    15

// AXI response codes
`define IFEB_RESP_OKAY    2'h0
`define IFEB_RESP_SLVERR  2'h2

`endif

// [design/ifeb_pkg.sv]
/*
 * Types shared by the flag and enable bank.
 * Assumes ifeb_map.svh supplies the numeric constants.
 */
`default_nettype none
package ifeb_pkg;

    // The three flag registers travel together
    typedef struct packed {
        logic [15:0] flags1;
        logic [15:0] flags3;
        logic [15:0] flags4;
    } ifeb_flags_t;

    // Register selected by a bus address
    typedef enum {
        IFEB_SEL_F1,
        IFEB_SEL_F3,
        IFEB_SEL_F4,
        IFEB_SEL_EN0,
        IFEB_SEL_NONE
    } ifeb_sel_t;

endpackage
`default_nettype wire

// [design/ifeb_bank.sv]
/*
 * Interrupt flag bank (three flag registers) and the first enable register,
 * reached over an AXI4-Lite slave.
 * Assumes event sources and the enabled-request consumer run on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ifeb_map.svh"

// Summary of operation
// [R1] A flag bit is set by its source's request pulse without software help.
// [R2] A flag reads 1 while its source has a request posted and 0 otherwise.
// [R3] An enable bit at 1 lets its source's request through, at 0 it blocks it.
// [R4] Unimplemented bits ignore writes and read as zero.
// [R5] Flags 1 holds uart b tx/rx and ext irq c at 15..13 and five flags at 4..0.
// [R6] Flags 3 holds only the calendar clock flag at bit 14.
// [R7] Flags 4 holds bits 13, 8, 3, 2 and 1 for the listed sources.
// [R8] Enables 0 holds bits 15, 13..7 and 3..0; bits 14 and 6..4 are absent.
// [R9] Every implemented bit is zero after reset.
// [R10] Software reads and writes every implemented bit and clears serviced flags.
// [R11] A hardware set in the same cycle as a software clear wins.
module ifeb_bank
    import ifeb_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              clk_i,         // System clock
    input  wire logic              rst_b_i,       // Sync reset, active low
    input  wire logic              ce_i,          // Clock enable
    input  wire ifeb_flags_t       flag_set_i,    // Request pulses per flag bit
    input  wire logic [15:0]       grp0_flags_i,  // Flags gated by enables 0
    output var  ifeb_flags_t       flags_o,       // Flag register contents
    output logic [15:0]            enables0_o,    // Enable register contents
    output logic [15:0]            grp0_req_o,    // Enabled requests
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
    input  wire logic              s_axi_awvalid, // Write address valid
    output logic                   s_axi_awready, // Write address ready
    input  wire logic [31:0]       s_axi_wdata,   // Write data
    input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes
    input  wire logic              s_axi_wvalid,  // Write data valid
    output logic                   s_axi_wready,  // Write data ready
    output logic [1:0]             s_axi_bresp,   // Write response
    output logic                   s_axi_bvalid,  // Write response valid
    input  wire logic              s_axi_bready,  // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
    input  wire logic              s_axi_arvalid, // Read address valid
    output logic                   s_axi_arready, // Read address ready
    output logic [31:0]            s_axi_rdata,   // Read data
    output logic [1:0]             s_axi_rresp,   // Read response
    output logic                   s_axi_rvalid,  // Read data valid
    input  wire logic              s_axi_rready   // Read data ready
);

    // The decoder needs room for the highest offset; refused at elaboration
    if (ADDR_W < 4)
    begin : g_addr_w_check
        $error("ADDR_W must be at least 4");
    end

    // Address to register, full decode so aliases answer as unmapped
    function automatic ifeb_sel_t reg_sel(input logic [ADDR_W-1:0] a);
        ifeb_sel_t s;
        s = IFEB_SEL_NONE;
        if (a == ADDR_W'(`IFEB_OFF_FLAGS1))
            s = IFEB_SEL_F1;
        else if (a == ADDR_W'(`IFEB_OFF_FLAGS3))
            s = IFEB_SEL_F3;
        else if (a == ADDR_W'(`IFEB_OFF_FLAGS4))
            s = IFEB_SEL_F4;
        else if (a == ADDR_W'(`IFEB_OFF_EN0))
            s = IFEB_SEL_EN0;
        return s;
    endfunction

    // Byte-merged write, kept to the implemented bits
    function automatic logic [15:0] upd(input logic [15:0] cur,
                                        input logic        hit,
                                        input logic [15:0] wd,
                                        input logic [15:0] wm,
                                        input logic [15:0] msk);
        logic [15:0] v;
        v = hit ? ((cur & ~wm) | (wd & wm)) : cur;
        return v & msk;
    endfunction

    ifeb_flags_t       flags_q;
    logic [15:0]       en0_q;
    logic [15:0]       req_q;
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [15:0]       wdata_q;
    logic [1:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic              wr_go;
    ifeb_sel_t         wr_sel;
    ifeb_sel_t         rd_sel;
    logic [15:0]       wmask;
    logic [15:0]       rd_val;

    // Readies drop with ce_i so no beat is taken while state is frozen
    assign s_axi_awready = ce_i & ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready  = ce_i & ~w_hold_q & ~bvalid_q;
    assign s_axi_arready = ce_i & ~rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign flags_o       = flags_q;
    assign enables0_o    = en0_q;
    assign grp0_req_o    = req_q;

    // Write commits one cycle after both address and data are held
    assign wr_go  = aw_hold_q & w_hold_q;
    assign wr_sel = reg_sel(waddr_q);
    assign rd_sel = reg_sel(s_axi_araddr);
    assign wmask  = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Write address holding register
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            aw_hold_q <= 1'b0;
            waddr_q   <= '0;
        end
        else if (ce_i)
        begin
            if (wr_go)
                aw_hold_q <= 1'b0;
            else if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                waddr_q   <= s_axi_awaddr;
            end
        end
    end

    // Write data holding register; only the low half-word matters
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            w_hold_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end
        else if (ce_i)
        begin
            if (wr_go)
                w_hold_q <= 1'b0;
            else if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata[15:0];
                wstrb_q  <= s_axi_wstrb[1:0];
            end
        end
    end

    // Write response; unmapped addresses get SLVERR and change nothing
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `IFEB_RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (wr_go)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= (wr_sel == IFEB_SEL_NONE) ? `IFEB_RESP_SLVERR
                                                      : `IFEB_RESP_OKAY;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // Read mux; registers keep only masked bits, so unimplemented bits read zero
    always_comb
    begin
        case (rd_sel)
            IFEB_SEL_F1:  rd_val = flags_q.flags1;  // see [R2] [R10]
            IFEB_SEL_F3:  rd_val = flags_q.flags3;
            IFEB_SEL_F4:  rd_val = flags_q.flags4;
            IFEB_SEL_EN0: rd_val = en0_q;
            default:      rd_val = 16'h0000;
        endcase
    end

    // Read channel, data registered at address acceptance
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rvalid_q <= 1'b0;
            rresp_q  <= `IFEB_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= {16'h0000, rd_val};  // see [R4]
                rresp_q  <= (rd_sel == IFEB_SEL_NONE) ? `IFEB_RESP_SLVERR
                                                      : `IFEB_RESP_OKAY;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    // Flags: software write first, then hardware sets OR in, so a set wins
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            flags_q <= '{default: `IFEB_RST_VAL};  // see [R9]
        end
        else if (ce_i)
        begin
            flags_q.flags1 <= upd(flags_q.flags1, wr_go && wr_sel == IFEB_SEL_F1,
                                  wdata_q, wmask, `IFEB_MASK_FLAGS1)
                              | (flag_set_i.flags1 & `IFEB_MASK_FLAGS1);  // see [R1] [R5] [R11]
            flags_q.flags3 <= upd(flags_q.flags3, wr_go && wr_sel == IFEB_SEL_F3,
                                  wdata_q, wmask, `IFEB_MASK_FLAGS3)
                              | (flag_set_i.flags3 & `IFEB_MASK_FLAGS3);  // see [R6] [R11]
            flags_q.flags4 <= upd(flags_q.flags4, wr_go && wr_sel == IFEB_SEL_F4,
                                  wdata_q, wmask, `IFEB_MASK_FLAGS4)
                              | (flag_set_i.flags4 & `IFEB_MASK_FLAGS4);  // see [R7] [R10]
        end
    end

    // Enable register, software only
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            en0_q <= `IFEB_RST_VAL;  // see [R9]
        else if (ce_i)
            en0_q <= upd(en0_q, wr_go && wr_sel == IFEB_SEL_EN0,
                         wdata_q, wmask, `IFEB_MASK_EN0);  // see [R8] [R4]
    end

    // Registered gating costs one cycle of latency but keeps the output glitch free
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            req_q <= 16'h0000;
        else if (ce_i)
            req_q <= grp0_flags_i & en0_q & `IFEB_MASK_EN0;  // see [R3]
    end

    // Checks on the bank's own behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_set_wins_clear: assert property ( // see [R11]
        ce_i && wr_go && wr_sel == IFEB_SEL_F1 && flag_set_i.flags1[15]
        |=> flags_q.flags1[15])
        else $error("hardware set lost against a write");

    a_set_posts_flag: assert property ( // see [R1]
        ce_i && flag_set_i.flags3[14] |=> flags_q.flags3[14])
        else $error("calendar flag not posted");

    a_flag_holds: assert property ( // see [R2]
        ce_i && !wr_go && flags_q.flags4[13] |=> flags_q.flags4[13])
        else $error("posted flag dropped without a write");

    a_unimpl_zero: assert property ( // see [R4]
        (flags_q.flags1 & ~`IFEB_MASK_FLAGS1) == 16'h0000
        && (flags_q.flags3 & ~`IFEB_MASK_FLAGS3) == 16'h0000
        && (flags_q.flags4 & ~`IFEB_MASK_FLAGS4) == 16'h0000
        && (en0_q & ~`IFEB_MASK_EN0) == 16'h0000)
        else $error("unimplemented bit is set");

    a_reset_clears: assert property ( // see [R9]
        @(posedge clk_i) disable iff (1'b0)
        !rst_b_i && ce_i |=> flags_q == '0 && en0_q == 16'h0000)
        else $error("register not zero after reset");

    a_enable_blocks: assert property ( // see [R3]
        ce_i && !en0_q[15] |=> !grp0_req_o[15])
        else $error("disabled request passed");

    a_enable_passes: assert property ( // see [R3]
        ce_i && en0_q[0] && grp0_flags_i[0] |=> grp0_req_o[0])
        else $error("enabled request blocked");

    a_read_flags: assert property ( // see [R10]
        ce_i && s_axi_arvalid && s_axi_arready && rd_sel == IFEB_SEL_F1
        |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(flags_q.flags1))
        else $error("read data differs from flag register");

    a_write_enable: assert property ( // see [R8]
        ce_i && wr_go && wr_sel == IFEB_SEL_EN0 && wstrb_q == 2'h3
        |=> en0_q == ($past(wdata_q) & `IFEB_MASK_EN0) && s_axi_bvalid)
        else $error("enable write not applied");

    a_bresp_stable: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    c_hw_set: cover property (ce_i && flag_set_i.flags1 != 16'h0000);
    c_sw_clear: cover property (wr_go && wr_sel == IFEB_SEL_F4 && flags_q.flags4 != 16'h0000);
    c_collide: cover property (wr_go && wr_sel == IFEB_SEL_F1 && flag_set_i.flags1 != 16'h0000);
    c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == `IFEB_RESP_SLVERR);

endmodule // ifeb_bank
`default_nettype wire

// [bench/ifeb_src.sv]
/*
 * Model of the peripheral event sources that feed the flag and enable bank.
 * Assumes the bench calls its tasks just after a rising edge of clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module ifeb_src
    import ifeb_pkg::*;
(
    input  wire logic   clk_i,        // System clock
    output var  ifeb_flags_t flag_set_o, // Request pulses
    output logic [15:0] grp0_flags_o  // Group 0 request levels
);
    // Sources stay quiet until told
    initial
    begin
        flag_set_o = '0;
        grp0_flags_o = 16'h0000;
    end

    // A request lasts one edge only, so a stuck set cannot hide a lost one
    task automatic fire(input ifeb_flags_t p);
        flag_set_o <= p;
        @(posedge clk_i);
        flag_set_o <= '0;
    endtask

    // Level requests of the enable-gated group
    task automatic hold(input logic [15:0] v);
        grp0_flags_o <= v;
    endtask
endmodule // ifeb_src
`default_nettype wire

// [bench/irq_flag_enable_bank_tb.sv]
/*
 * Self-checking bench of the flag and enable bank.
 * Assumes the bank answers on AXI4-Lite and ifeb_src stands for the sources.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ifeb_map.svh"
module irq_flag_enable_bank_tb
    import ifeb_pkg::*;
;
    logic        clk_i, rst_b_i, ce_i, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
    ifeb_flags_t fset, flags;
    logic [15:0] grp0, en0, req;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp;
    int          errors, checks;
    localparam logic [7:0] OFF [4] = '{`IFEB_OFF_FLAGS1, `IFEB_OFF_FLAGS3,
                                       `IFEB_OFF_FLAGS4, `IFEB_OFF_EN0};
    localparam logic [15:0] MSK [4] = '{`IFEB_MASK_FLAGS1, `IFEB_MASK_FLAGS3,
                                        `IFEB_MASK_FLAGS4, `IFEB_MASK_EN0};

    ifeb_bank u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .flag_set_i(fset),
        .grp0_flags_i(grp0), .flags_o(flags), .enables0_o(en0), .grp0_req_o(req),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr));
    ifeb_src u_src (.clk_i(clk_i), .flag_set_o(fset), .grp0_flags_o(grp0));

    // 100 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic stop_test;
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [47:0] s, input logic [47:0] e, input string m);
        checks++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // Handshakes are judged at the falling edge, where they equal what the rising edge takes
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input ifeb_flags_t p,
                      input logic [1:0] er);
        logic       ah;
        logic       wh;
        logic       bh;
        logic [1:0] r;
        awa <= a;
        wd  <= {16'h0000, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        for (int n = 0; n < 64; n++)
        begin
            @(negedge clk_i);
            ah = awv && awr;
            wh = wv && wr_r;
            bh = bv && br;
            r  = bresp;
            @(posedge clk_i);
            if (ah)
                awv <= 1'b0;
            if (wh)
            begin
                wv <= 1'b0;
                // The pulse is sampled on the edge that commits this write
                if (p !== '0)
                    fork u_src.fire(p); join_none
            end
            if (bh)
            begin
                br <= 1'b0;
                chk({46'h0, r}, {46'h0, er}, "write response");
                // Let an edge pass so the next call never raises bready in this step
                @(posedge clk_i);
                return;
            end
        end
        errors++;
        stop_test();
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
        logic        ah;
        logic        rh;
        logic [31:0] d;
        logic [1:0]  r;
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        for (int n = 0; n < 64; n++)
        begin
            @(negedge clk_i);
            ah = arv && arr;
            rh = rv && rr;
            d  = rdat;
            r  = rresp;
            @(posedge clk_i);
            if (ah)
                arv <= 1'b0;
            if (rh)
            begin
                rr <= 1'b0;
                chk({16'h0, d}, {32'h0, e}, "read data");
                chk({46'h0, r}, {46'h0, er}, "read response");
                // Let an edge pass so the next call never raises rready in this step
                @(posedge clk_i);
                return;
            end
        end
        errors++;
        stop_test();
    endtask

    task automatic t_reset;
        for (int i = 0; i < 4; i++)
            rd(OFF[i], 16'h0000, `IFEB_RESP_OKAY);
        @(negedge clk_i);
        chk(flags, '0, "flags after reset");
        chk({32'h0, en0}, '0, "enables after reset");
        @(posedge clk_i);
    endtask

    // Ones, then zeros, then only the absent bits, into every register
    task automatic t_rw;
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF[i], 16'hFFFF, '0, `IFEB_RESP_OKAY);
            rd(OFF[i], MSK[i], `IFEB_RESP_OKAY);
            wr(OFF[i], 16'h0000, '0, `IFEB_RESP_OKAY);
            rd(OFF[i], 16'h0000, `IFEB_RESP_OKAY);
            wr(OFF[i], ~MSK[i], '0, `IFEB_RESP_OKAY);
            rd(OFF[i], 16'h0000, `IFEB_RESP_OKAY);
        end
    endtask

    task automatic t_hwset;
        u_src.fire('1);
        @(negedge clk_i);
        chk(flags, {`IFEB_MASK_FLAGS1, `IFEB_MASK_FLAGS3, `IFEB_MASK_FLAGS4},
            "hardware set");
        @(posedge clk_i);
        rd(OFF[2], MSK[2], `IFEB_RESP_OKAY);
        for (int i = 0; i < 3; i++)
            wr(OFF[i], 16'h0000, '0, `IFEB_RESP_OKAY);
        @(negedge clk_i);
        chk(flags, '0, "software clear");
        @(posedge clk_i);
    endtask

    // Requests land on the very edge that commits a clearing write
    task automatic t_setwins;
        wr(OFF[0], 16'h0000, {16'h8000, 16'h0000, 16'h0000}, `IFEB_RESP_OKAY);
        rd(OFF[0], 16'h8000, `IFEB_RESP_OKAY);
        wr(OFF[1], 16'h0000, {16'h0000, 16'h4000, 16'h0000}, `IFEB_RESP_OKAY);
        rd(OFF[1], 16'h4000, `IFEB_RESP_OKAY);
        wr(OFF[0], 16'h0000, '0, `IFEB_RESP_OKAY);
        wr(OFF[1], 16'h0000, '0, `IFEB_RESP_OKAY);
    endtask

    task automatic t_gate;
        u_src.hold(16'hFFFF);
        wr(OFF[3], 16'hFFFF, '0, `IFEB_RESP_OKAY);
        @(posedge clk_i);
        @(negedge clk_i);
        chk({32'h0, req}, {32'h0, MSK[3]}, "enabled requests");
        @(posedge clk_i);
        u_src.hold(16'h4401);
        @(posedge clk_i);
        @(negedge clk_i);
        chk({32'h0, req}, {32'h0, 16'h0401}, "absent enable");
        @(posedge clk_i);
        wr(OFF[3], 16'h0000, '0, `IFEB_RESP_OKAY);
        @(negedge clk_i);
        chk({32'h0, req}, '0, "blocked requests");
        @(posedge clk_i);
    endtask

    task automatic t_unmapped;
        wr(8'h10, 16'hFFFF, '0, `IFEB_RESP_SLVERR);
        rd(8'h10, 16'h0000, `IFEB_RESP_SLVERR);
        rd(OFF[0], 16'h0000, `IFEB_RESP_OKAY);
    endtask

    // A frozen enable drops requests; a reset in mid-run clears live state
    task automatic t_freeze;
        ce_i <= 1'b0;
        u_src.fire('1);
        ce_i <= 1'b1;
        @(negedge clk_i);
        chk(flags, '0, "request taken while frozen");
        @(posedge clk_i);
        wr(OFF[3], 16'hFFFF, '0, `IFEB_RESP_OKAY);
        u_src.fire('1);
        rst_b_i <= 1'b0;
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        chk(flags, '0, "flags after mid-run reset");
        chk({32'h0, en0}, '0, "enables after mid-run reset");
        chk({32'h0, req}, '0, "requests after mid-run reset");
        @(posedge clk_i);
        rd(OFF[3], 16'h0000, `IFEB_RESP_OKAY);
    endtask

    // Reset for four cycles, then the scenarios
    initial
    begin
        errors = 0; checks = 0; rst_b_i = 1'b0; ce_i = 1'b1;
        awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'hF;
        awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_rw();
        t_hwset();
        t_setwins();
        t_gate();
        t_unmapped();
        t_freeze();
        stop_test();
    end
endmodule // irq_flag_enable_bank_tb
`default_nettype wire
